/* File: include/sr_bm_consts.vh */
/*
 * Constants for the sample record basic/memory field framer: word counts,
 * field positions, configuration bits and record sizes.
 * Assumes inclusion by bare name from design files that need these values.
 */
`ifndef SR_BM_CONSTS_VH
`define SR_BM_CONSTS_VH

// Record format word: size field position.
`define SRBM_SIZE_LSB        48
`define SRBM_SIZE_MSB        63
`define SRBM_FMT_MSB         47
// Group selection: memory group enable bit.
`define SRBM_CFG_MEM_BIT     0
// Bytes per record word.
`define SRBM_WORD_BYTES      16'h0008
// Basic group word count and memory group word count.
`define SRBM_BASIC_WORDS     3'h4
`define SRBM_MEM_WORDS       3'h4
// Updated access-information word field positions.
`define SRBM_SRC_LSB         0
`define SRBM_SRC_MSB         3
`define SRBM_TLB_MISS_BIT    4
`define SRBM_LOCK_BIT        5
`define SRBM_DATA_BLK_BIT    6
`define SRBM_ADDR_BLK_BIT    7
// Latency word field positions.
`define SRBM_INSN_LAT_MSB    15
`define SRBM_CACHE_LAT_LSB   32
`define SRBM_CACHE_LAT_MSB   47
// Transactional word split.
`define SRBM_TX_CYC_MSB      31
`define SRBM_TX_ABORT_LSB    32

`endif

/* File: verilog/srbm_lat_counter.v */
/*
 * Saturating cycle counter for one latency measurement.
 * Assumes start and stop are one-cycle pulses on the same clock.
 */
`timescale 1ns/10ps
`default_nettype none

module srbm_lat_counter #(
  parameter WIDTH = 16
) (
  input  wire             clk,
  input  wire             srst,
  input  wire             start,
  input  wire             stop,
  output reg  [WIDTH-1:0] count_r
);

  reg running_r;

  // Count while running; saturate so a long stall never wraps to a small value.
  always @(posedge clk) begin
    if (srst) begin
      running_r <= 1'b0;
      count_r   <= {WIDTH{1'b0}};
    end else if (start) begin
      running_r <= 1'b1;
      count_r   <= {WIDTH{1'b0}};
    end else if (running_r) begin
      if (stop) begin
        running_r <= 1'b0;
      end
      if (~&count_r) begin
        count_r <= count_r + {{(WIDTH-1){1'b0}}, 1'b1};
      end
    end
  end

endmodule // srbm_lat_counter

`default_nettype wire

/* File: verilog/srbm_framer.v */
/*
 * Sample record framer for the tail of the basic group and the memory
 * access group, original or updated layout, emitted one 64-bit word a cycle.
 * Assumes capture inputs are on clk, and that the sink accepts one word per
 * cycle while word_valid is high (no back-pressure).
 */
// What this block does
// - Instruction pointer word is triggering instruction address.
// - No next-instruction pointer word is emitted.
// - One applicable-counter bit per triggering counter.
// - Timestamp word is time stamp counter at generation.
// - Original layout: canonical access linear address.
// - Auxiliary word: load source or store status.
// - Latency word: load service cycles.
// - Original transactional word: cycles low, abort high.
// - Updated word 0: address, zero if unknown.
// - Updated word 8H bits 3:0: data source.
// - Bit 4: second-level TLB miss.
// - Bit 5: locked atomic access.
// - Bit 6: load blocked on store forwarding.
// - Bit 7: load blocked on address overlap.
// - Word 10H bits 15:0: instruction latency.
// - Word 10H bits 47:32: cache latency.
// - Store cache latency: L1 write to line done.
// - Word 18H: region cycles low, abort high.
// - First word bits 63:48 hold record bytes.
// - Memory group only when config bit 0 set.
`timescale 1ns/10ps
`default_nettype none
`include "sr_bm_consts.vh"

module srbm_framer #(
  parameter CNT_W = 64,
  parameter LAT_W = 16
) (
  input  wire        clk,
  input  wire        srst,
  input  wire        trigger,
  input  wire [63:0] counters_fired,
  input  wire [63:0] retired_ip,
  input  wire [63:0] time_stamp_counter,
  input  wire [47:0] group_cfg,
  input  wire        adaptive,
  input  wire        updated_layout,
  input  wire        access_is_store,
  input  wire [63:0] data_linear_address,
  input  wire        address_valid,
  input  wire [63:0] load_source_enc,
  input  wire [63:0] store_status_enc,
  input  wire        mem_event_in_gp,
  input  wire [3:0]  data_source,
  input  wire        second_level_tlb_miss,
  input  wire        locked_access_flag,
  input  wire        data_block,
  input  wire        address_block,
  input  wire        insn_lat_start,
  input  wire        insn_lat_stop,
  input  wire        cache_lat_start,
  input  wire        cache_lat_stop,
  input  wire [31:0] tx_cycles,
  input  wire [31:0] tx_abort_info,
  output reg  [63:0] word_data,
  output reg         word_valid,
  output reg         word_last,
  output reg         busy
);

  localparam ST_IDLE = 1'b0;
  localparam ST_EMIT = 1'b1;

  reg        state_r;
  reg [2:0]  idx_r;
  reg        mem_sel_r;
  reg [63:0] fmt_r;
  reg [63:0] ip_r;
  reg [63:0] app_r;
  reg [63:0] tsc_r;
  reg [63:0] mem_w_r [0:3];
  reg [63:0] mem_nxt [0:3];
  reg [15:0] size_nxt;
  reg [63:0] addr_nxt;
  reg [63:0] aux_nxt;
  wire [LAT_W-1:0] insn_lat;
  wire [LAT_W-1:0] cache_lat;
  wire       mem_sel;
  wire [2:0] last_idx;

  ////////////////////////////////////////////////////////////////////////////
  // Latency counters: the capture side supplies the start and end points,
  // which for stores already mark L1 write to line completion.
  srbm_lat_counter #(.WIDTH(LAT_W)) u_insn_lat (
    .clk     (clk),
    .srst    (srst),
    .start   (insn_lat_start),
    .stop    (insn_lat_stop),
    .count_r (insn_lat)
  );

  srbm_lat_counter #(.WIDTH(LAT_W)) u_cache_lat (
    .clk     (clk),
    .srst    (srst),
    .start   (cache_lat_start),
    .stop    (cache_lat_stop),
    .count_r (cache_lat)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Memory group only for adaptive records with the memory bit set.
  assign mem_sel  = adaptive & group_cfg[`SRBM_CFG_MEM_BIT];
  assign last_idx = mem_sel_r ? 3'h7 : 3'h3;

  // Build the memory group words for whichever layout is selected.
  always @* begin
    size_nxt = `SRBM_WORD_BYTES * {13'h0000, `SRBM_BASIC_WORDS};
    if (mem_sel) begin
      size_nxt = size_nxt + `SRBM_WORD_BYTES * {13'h0000, `SRBM_MEM_WORDS};
    end
    addr_nxt = address_valid ? data_linear_address : 64'h0;
    aux_nxt  = 64'h0;
    if (mem_event_in_gp) begin
      aux_nxt = access_is_store ? store_status_enc : load_source_enc;
    end
    mem_nxt[0] = addr_nxt;
    mem_nxt[1] = aux_nxt;
    mem_nxt[2] = mem_event_in_gp ? {{(64-LAT_W){1'b0}}, insn_lat} : 64'h0;
    mem_nxt[3] = {tx_abort_info, tx_cycles};
    if (updated_layout) begin
      mem_nxt[1] = 64'h0;
      mem_nxt[1][`SRBM_SRC_MSB:`SRBM_SRC_LSB] = data_source;
      mem_nxt[1][`SRBM_TLB_MISS_BIT] = second_level_tlb_miss;
      mem_nxt[1][`SRBM_LOCK_BIT]     = locked_access_flag;
      // Block bits mean something only once software counts the forwarding
      // block event; they pass through as reported.
      mem_nxt[1][`SRBM_DATA_BLK_BIT] = data_block;
      mem_nxt[1][`SRBM_ADDR_BLK_BIT] = address_block;
      mem_nxt[2] = 64'h0;
      mem_nxt[2][LAT_W-1:0] = insn_lat;
      mem_nxt[2][`SRBM_CACHE_LAT_LSB+LAT_W-1:`SRBM_CACHE_LAT_LSB] = cache_lat;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Capture on trigger, then stream words back to back.
  // Triggers during emission are ignored; the core holds off the next one.
  always @(posedge clk) begin
    if (srst) begin
      state_r    <= ST_IDLE;
      idx_r      <= 3'h0;
      mem_sel_r  <= 1'b0;
      fmt_r      <= 64'h0;
      ip_r       <= 64'h0;
      app_r      <= 64'h0;
      tsc_r      <= 64'h0;
      word_data  <= 64'h0;
      word_valid <= 1'b0;
      word_last  <= 1'b0;
      busy       <= 1'b0;
    end else begin
      case (state_r)
        ST_IDLE: begin
          word_valid <= 1'b0;
          word_last  <= 1'b0;
          if (trigger) begin
            state_r   <= ST_EMIT;
            busy      <= 1'b1;
            idx_r     <= 3'h0;
            mem_sel_r <= mem_sel;
            fmt_r     <= {size_nxt, (adaptive ? group_cfg : 48'h0)};
            ip_r      <= retired_ip;
            app_r     <= counters_fired;
            tsc_r     <= time_stamp_counter;
          end
        end
        ST_EMIT: begin
          word_valid <= 1'b1;
          word_last  <= (idx_r == last_idx);
          case (idx_r)
            3'h0:    word_data <= fmt_r;
            3'h1:    word_data <= ip_r;
            3'h2:    word_data <= app_r;
            3'h3:    word_data <= tsc_r;
            default: word_data <= mem_w_r[idx_r[1:0]];
          endcase
          // No gap between words or groups.
          if (idx_r == last_idx) begin
            state_r <= ST_IDLE;
            busy    <= 1'b0;
          end else begin
            idx_r <= idx_r + 3'h1;
          end
        end
        default: begin
          state_r <= ST_IDLE;
        end
      endcase
    end
  end

  // Memory words are frozen at trigger so later activity cannot alter them.
  genvar g;
  generate
    for (g = 0; g < 4; g = g + 1) begin : g_mem
      always @(posedge clk) begin
        if (srst) begin
          mem_w_r[g] <= 64'h0;
        end else if (state_r == ST_IDLE && trigger) begin
          mem_w_r[g] <= mem_nxt[g];
        end
      end
    end
  endgenerate

endmodule // srbm_framer

`default_nettype wire

/* File: test/srbm_sva.sv */
/* Checker for the sample record framer's word stream.
   Assumes a bind to srbm_framer and port names matching its ports. */
`timescale 1ns/10ps
`default_nettype none
module srbm_sva (
  input wire logic        clk,
  input wire logic        srst,
  input wire logic        trigger,
  input wire logic        busy,
  input wire logic        word_valid,
  input wire logic        word_last,
  input wire logic [63:0] word_data,
  input wire logic [63:0] retired_ip,
  input wire logic [63:0] data_linear_address,
  input wire logic        address_valid,
  input wire logic [31:0] tx_cycles,
  input wire logic [31:0] tx_abort_info
);
  // All checks run on the core clock and are quiet during reset.
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);
  property p_start; trigger && !busy && !word_valid |=> busy ##1 word_valid; endproperty
  a_start: assert property (p_start) else $error("no record after trigger");
  property p_size; $rose(word_valid) |-> word_data[63:48] == (word_data[0] ? 16'h0040 : 16'h0020);
  endproperty
  a_size: assert property (p_size) else $error("record size wrong");
  property p_ip; $rose(word_valid) |=> word_data == $past(retired_ip, 3); endproperty
  a_ip: assert property (p_ip) else $error("pointer word wrong");
  property p_basic; $rose(word_valid) && !word_data[0] |-> word_valid[*4] ##1 !word_valid;
  endproperty
  a_basic: assert property (p_basic) else $error("basic record length wrong");
  property p_mem; $rose(word_valid) && word_data[0] |-> word_valid[*8] ##1 !word_valid; endproperty
  a_mem: assert property (p_mem) else $error("memory record length wrong");
  property p_last; word_last |-> word_valid ##1 !word_valid; endproperty
  a_last: assert property (p_last) else $error("last flag misplaced");
  property p_addr; $rose(word_valid) && word_data[0] |-> ##4
    word_data == ($past(address_valid, 6) ? $past(data_linear_address, 6) : 64'h0); endproperty
  a_addr: assert property (p_addr) else $error("address word wrong");
  property p_tx; $rose(word_valid) && word_data[0] |-> ##7
    word_data == {$past(tx_abort_info, 9), $past(tx_cycles, 9)}; endproperty
  a_tx: assert property (p_tx) else $error("transaction word wrong");
  cover property (trigger && !busy && !word_valid);
  cover property ($rose(word_valid) && word_data[0]);
  cover property (trigger && busy);
endmodule // srbm_sva
bind srbm_framer srbm_sva u_sva (.*);
`default_nettype wire

/* File: test/srbm_sink.sv */
/* Record reader model: software taking each word from the buffer.
   Assumes no back-pressure, so every valid word is taken at once. */
`timescale 1ns/10ps
`default_nettype none
module srbm_sink (
  input  wire logic        clk,
  input  wire logic        word_valid,
  input  wire logic        word_last,
  input  wire logic [63:0] word_data,
  output var  logic        got,
  output var  logic        last,
  output var  logic [63:0] data
);
  // Every word is taken as it comes, one cycle after the framer drives it.
  always @(posedge clk) begin
    got  <= word_valid;
    last <= word_last;
    data <= word_data;
  end
endmodule // srbm_sink
`default_nettype wire

/* File: test/tb_top.sv */
/* Self-checking bench for the sample record framer.
   Assumes the framer is idle after reset and needs no back-pressure. */
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  logic clk = 0, srst = 1, trigger = 0, adaptive = 0, updated_layout = 0, access_is_store = 0;
  logic address_valid = 0, mem_event_in_gp = 0, second_level_tlb_miss = 0;
  logic locked_access_flag = 0, data_block = 0, address_block = 0, lat_go = 0;
  logic [63:0] counters_fired = 0, retired_ip = 0, time_stamp_counter = 0;
  logic [63:0] data_linear_address = 0, load_source_enc = 0, store_status_enc = 0;
  logic [47:0] group_cfg = 0;
  logic [3:0]  data_source = 0;
  logic [31:0] tx_cycles = 0, tx_abort_info = 0, seed = 32'h5f;
  logic        word_valid, word_last, busy, got, gl;
  logic [63:0] word_data, gd;
  logic [64:0] q[$], x;
  int bad_count = 0, comparisons = 0, cyc = 0;
  always #20 clk = ~clk;
  srbm_framer dut (.*, .insn_lat_start(lat_go), .insn_lat_stop(1'b0),
    .cache_lat_start(lat_go), .cache_lat_stop(1'b0));
  srbm_sink u_sink (.clk(clk), .word_valid(word_valid), .word_last(word_last),
    .word_data(word_data), .got(got), .last(gl), .data(gd));
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // One record; trigger stays high a second cycle, which the busy framer must ignore.
  task automatic rec(input logic [3:0] m);
    logic [31:0] e;
    logic [15:0] l;
    logic mem;
    while ((busy | word_valid) !== 1'b0) begin
      @(posedge clk) #1;
    end
    {adaptive, updated_layout, access_is_store} = m[2:0];
    group_cfg = {16'h0, rnd()};
    group_cfg[0] = m[3];
    retired_ip = {rnd(), rnd()};
    counters_fired = {rnd(), rnd()};
    time_stamp_counter = {rnd(), rnd()};
    data_linear_address = {rnd(), rnd()};
    load_source_enc = {rnd(), rnd()};
    store_status_enc = {rnd(), rnd()};
    tx_cycles = rnd();
    tx_abort_info = rnd();
    e = rnd();
    {address_block, data_block, locked_access_flag, second_level_tlb_miss} = e[9:6];
    {data_source, mem_event_in_gp, address_valid} = e[5:0];
    // Both latency counters start together; l cycles later the record is taken.
    l = {13'h0, e[12:10]};
    lat_go = 1;
    @(posedge clk) #1;
    lat_go = 0;
    repeat (l) begin
      @(posedge clk) #1;
    end
    trigger = 1;
    mem = m[2] & m[3];
    q.push_back({1'b0, mem ? 16'h0040 : 16'h0020, m[2] ? group_cfg : 48'h0});
    q.push_back({1'b0, retired_ip});
    q.push_back({1'b0, counters_fired});
    q.push_back({!mem, time_stamp_counter});
    if (mem) begin
      q.push_back({1'b0, address_valid ? data_linear_address : 64'h0});
      q.push_back({1'b0, m[1] ? {56'h0, e[9:2]} : !e[1] ? 64'h0 : m[0] ? store_status_enc :
        load_source_enc});
      q.push_back({1'b0, m[1] ? {16'h0, l, 16'h0, l} : e[1] ? {48'h0, l} : 64'h0});
      q.push_back({1'b1, tx_abort_info, tx_cycles});
    end
    @(posedge clk) #1;
    retired_ip = ~retired_ip;
    @(posedge clk) #1;
    trigger = 0;
    $display("record mode %h done", m);
  endtask
  // Compare each word taken by the reader with the oldest note.
  always @(posedge clk) begin
    if (got === 1'b1) begin
      comparisons++;
      x = q.size() > 0 ? q.pop_front() : 65'h0;
      if ({gl, gd} !== x) begin
        bad_count++;
        $display("unexpected word expected %h seen %h", x, {gl, gd});
      end
    end
  end
  // Cut a hang short.
  always @(posedge clk) begin
    cyc++;
    if (cyc == 2000) begin
      bad_count++;
      $display("unexpected timeout expected idle seen busy");
      finish_test();
    end
  end
  initial begin
    repeat (10) @(posedge clk);
    #1 srst = 0;
    for (int i = 0; i < 32; i++) rec(i[3:0]);
    repeat (12) @(posedge clk);
    comparisons++;
    if (q.size() != 0) begin
      bad_count++;
      $display("unexpected queue expected 0 seen %0d", q.size());
    end
    finish_test();
  end
endmodule // tb_top
`default_nettype wire
